/* verilog/gpab_pkg.sv */
`default_nettype none

package gpab_pkg;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] ADDR_PORT_A_DATA = 8'h00;
    localparam logic [7:0] ADDR_PORT_B_DATA = 8'h01;
    localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h04;
    localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h05;
    localparam logic [7:0] ADDR_PORT_A_PULLUP = 8'h0D;
    localparam logic [7:0] ADDR_PORT_A7_PULLUP = 8'h0E;
    localparam logic [7:0] ADDR_CONTROL = 8'h10;

    // ========================================================================
    // Field positions and reset values
    // ========================================================================
    localparam int OSC_IO_SEL_BIT = 7;
    localparam int A7_PULLUP_BIT = 0;
    localparam int CTRL_CRYSTAL_BIT = 0;
    localparam int CTRL_TWO_WIRE_SEL_BIT = 1;
    localparam int CTRL_TWO_WIRE_EN_BIT = 2;
    localparam int OSC_PIN = 6;
    localparam int TWO_WIRE_DATA_PIN = 2;
    localparam int TWO_WIRE_CLOCK_PIN = 3;
    localparam logic [7:0] RESET_DIRECTION = 8'h00;
    localparam logic [7:0] RESET_PULLUP = 8'h00;
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic RESET_OSC_IO_SEL = 1'b1;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ========================================================================
    // Pin bundle for one 8-bit port
    // ========================================================================
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } gpab_pins_s;

endpackage

`default_nettype wire

/* verilog/gpab_ports.sv */
// Summary of operation
// - Port A has eight software read/write latches, untouched by reset.
// - Port A direction bit 1 drives the pin; 0 leaves it an input.
// - Reset clears all port A direction bits.
// - Port A data read returns latch for outputs, pin level for inputs.
// - Data latch writes always land; inputs still read the pin.
// - Port A pull-up on when its enable is 1 and pin is input.
// - Port A pull-up off whenever its enable is 0.
// - Port A pull-up switched off automatically while the pin outputs.
// - With RC option, select bit picks bit 6 I/O or RC clock out.
// - With crystal option, the select bit has no effect on the pin.
// - Keyboard enables route matching port A pins to keyboard interrupts.
// - An option bit selects port A pins 2 and 3 for two-wire use.
// - Port B has eight software read/write latches, untouched by reset.
// - Port B direction 1 drives, 0 inputs; reset clears all bits.
// - Port B read returns latch or pin; inputs have no pull-up.
// - Port B pins feed converter channels 0 to 7 by channel select.
// - Enabled two-wire unit on pins 2 and 3 beats keyboard interrupts.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module gpab_ports
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [7:0] port_a_pin_i,
    output gpab_pkg::gpab_pins_s port_a_pin_o,
    output logic [7:0] port_a_pullup_o,
    input wire logic [7:0] port_b_pin_i,
    output gpab_pkg::gpab_pins_s port_b_pin_o,
    input wire logic [7:0] keyboard_irq_enable_i,
    output logic [7:0] keyboard_pin_o,
    output logic [7:0] keyboard_irq_active_o,
    input wire logic rc_clock_i,
    input wire logic two_wire_sda_out_i,
    input wire logic two_wire_sda_oe_i,
    input wire logic two_wire_scl_out_i,
    input wire logic two_wire_scl_oe_i,
    output logic two_wire_sda_o,
    output logic two_wire_scl_o,
    input wire logic [4:0] converter_channel_select_i,
    output logic converter_analog_o
);

    // ========================================================================
    // Registers
    // ========================================================================
    logic [7:0] port_a_data;
    logic [7:0] port_b_data;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [6:0] port_a_pullup_enable;
    logic osc_pin_io_select;
    logic port_a_bit7_pullup_enable;
    logic [7:0] control;
    logic [7:0] a_sync1;
    logic [7:0] a_sync2;
    logic [7:0] b_sync1;
    logic [7:0] b_sync2;
    logic [7:0] pullup_en_all;
    logic crystal_option;
    logic rc_clock_active;
    logic two_wire_active;
    logic [7:0] next_a_out;
    logic [7:0] next_a_oe;
    logic [7:0] next_pullup;
    logic [7:0] next_kbd_active;
    logic [7:0] next_rdata;

    assign crystal_option = control[gpab_pkg::CTRL_CRYSTAL_BIT];
    assign rc_clock_active = !crystal_option && !osc_pin_io_select;
    assign two_wire_active = control[gpab_pkg::CTRL_TWO_WIRE_SEL_BIT]
        && control[gpab_pkg::CTRL_TWO_WIRE_EN_BIT];
    assign pullup_en_all = {port_a_bit7_pullup_enable,
        port_a_pullup_enable[6:0]};

    // Data latches have no reset on purpose: reset leaves their contents.
    always_ff @(posedge sys_clk_i)
    begin
        if (reg_write_i && reg_addr_i == gpab_pkg::ADDR_PORT_A_DATA)
        begin
            port_a_data <= reg_wdata_i;
        end
        if (reg_write_i && reg_addr_i == gpab_pkg::ADDR_PORT_B_DATA)
        begin
            port_b_data <= reg_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            port_a_direction <= gpab_pkg::RESET_DIRECTION;
            port_b_direction <= gpab_pkg::RESET_DIRECTION;
        end
        else if (reg_write_i)
        begin
            if (reg_addr_i == gpab_pkg::ADDR_PORT_A_DIRECTION)
            begin
                port_a_direction <= reg_wdata_i;
            end
            if (reg_addr_i == gpab_pkg::ADDR_PORT_B_DIRECTION)
            begin
                port_b_direction <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            port_a_pullup_enable <= gpab_pkg::RESET_PULLUP[6:0];
            osc_pin_io_select <= gpab_pkg::RESET_OSC_IO_SEL;
            port_a_bit7_pullup_enable <= 1'b0;
            control <= gpab_pkg::RESET_CONTROL;
        end
        else if (reg_write_i)
        begin
            if (reg_addr_i == gpab_pkg::ADDR_PORT_A_PULLUP)
            begin
                port_a_pullup_enable <= reg_wdata_i[6:0];
                osc_pin_io_select <= reg_wdata_i[gpab_pkg::OSC_IO_SEL_BIT];
            end
            if (reg_addr_i == gpab_pkg::ADDR_PORT_A7_PULLUP)
            begin
                port_a_bit7_pullup_enable <=
                    reg_wdata_i[gpab_pkg::A7_PULLUP_BIT];
            end
            if (reg_addr_i == gpab_pkg::ADDR_CONTROL)
            begin
                control <= reg_wdata_i;
            end
        end
    end

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    // Two stages keep a metastable pin out of the read path.
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            a_sync1 <= 8'h00;
            a_sync2 <= 8'h00;
            b_sync1 <= 8'h00;
            b_sync2 <= 8'h00;
        end
        else
        begin
            a_sync1 <= port_a_pin_i;
            a_sync2 <= a_sync1;
            b_sync1 <= port_b_pin_i;
            b_sync2 <= b_sync1;
        end
    end

    // ========================================================================
    // Per-pin output logic for port A
    // ========================================================================
    // The latch may hold garbage after power-up; it is only driven once
    // software sets the direction bit, so it reaches a pin unset if that bit is set before the latch is written.
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_pin_a
            always_comb
            begin
                next_a_out[i] = port_a_data[i];
                next_a_oe[i] = port_a_direction[i];
                next_pullup[i] = pullup_en_all[i]
                    && !port_a_direction[i];
                next_kbd_active[i] = keyboard_irq_enable_i[i];
                if (i == gpab_pkg::OSC_PIN && rc_clock_active)
                begin
                    next_a_out[i] = rc_clock_i;
                    next_a_oe[i] = 1'b1;
                    next_pullup[i] = 1'b0;
                    next_kbd_active[i] = 1'b0;
                end
                if (two_wire_active && i == gpab_pkg::TWO_WIRE_DATA_PIN)
                begin
                    next_a_out[i] = two_wire_sda_out_i;
                    next_a_oe[i] = two_wire_sda_oe_i;
                    // A line the two-wire unit drives gets no pull-up.
                    next_pullup[i] = next_pullup[i]
                        && !two_wire_sda_oe_i;
                    next_kbd_active[i] = 1'b0;
                end
                if (two_wire_active && i == gpab_pkg::TWO_WIRE_CLOCK_PIN)
                begin
                    next_a_out[i] = two_wire_scl_out_i;
                    next_a_oe[i] = two_wire_scl_oe_i;
                    next_pullup[i] = next_pullup[i]
                        && !two_wire_scl_oe_i;
                    next_kbd_active[i] = 1'b0;
                end
            end
        end
    endgenerate

    // ========================================================================
    // Read data mux
    // ========================================================================
    always_comb
    begin
        next_rdata = gpab_pkg::READ_UNMAPPED;
        case (reg_addr_i)
            gpab_pkg::ADDR_PORT_A_DATA:
                next_rdata = (port_a_direction & port_a_data)
                    | (~port_a_direction & a_sync2);
            gpab_pkg::ADDR_PORT_B_DATA:
                next_rdata = (port_b_direction & port_b_data)
                    | (~port_b_direction & b_sync2);
            gpab_pkg::ADDR_PORT_A_DIRECTION:
                next_rdata = port_a_direction;
            gpab_pkg::ADDR_PORT_B_DIRECTION:
                next_rdata = port_b_direction;
            gpab_pkg::ADDR_PORT_A_PULLUP:
                next_rdata = {osc_pin_io_select, port_a_pullup_enable[6:0]};
            gpab_pkg::ADDR_PORT_A7_PULLUP:
                next_rdata = {7'h00, port_a_bit7_pullup_enable};
            gpab_pkg::ADDR_CONTROL:
                next_rdata = control;
            default:
                next_rdata = gpab_pkg::READ_UNMAPPED;
        endcase
    end

    // ========================================================================
    // Registered outputs
    // ========================================================================
    // Every output adds one cycle of delay; the pins lag a write by one edge.
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            reg_rdata_o <= 8'h00;
            port_a_pin_o <= '0;
            port_b_pin_o <= '0;
            port_a_pullup_o <= 8'h00;
            keyboard_pin_o <= 8'h00;
            keyboard_irq_active_o <= 8'h00;
            two_wire_sda_o <= 1'b0;
            two_wire_scl_o <= 1'b0;
            converter_analog_o <= 1'b0;
        end
        else
        begin
            reg_rdata_o <= reg_read_i ? next_rdata : 8'h00;
            port_a_pin_o.out <= next_a_out;
            port_a_pin_o.oe <= next_a_oe;
            port_b_pin_o.out <= port_b_data;
            port_b_pin_o.oe <= port_b_direction;
            port_a_pullup_o <= next_pullup;
            keyboard_pin_o <= a_sync2;
            keyboard_irq_active_o <= next_kbd_active;
            two_wire_sda_o <= a_sync2[gpab_pkg::TWO_WIRE_DATA_PIN];
            two_wire_scl_o <= a_sync2[gpab_pkg::TWO_WIRE_CLOCK_PIN];
            // Digital view of the chosen channel; codes above 7 read 0.
            converter_analog_o <= (converter_channel_select_i[4:3] == 2'b00)
                ? b_sync2[converter_channel_select_i[2:0]] : 1'b0;
        end
    end

endmodule // gpab_ports

`default_nettype wire

/* test/gpab_ports_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module gpab_ports_assertions
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] port_a_pin_i,
    input wire gpab_pkg::gpab_pins_s port_a_pin_o,
    input wire logic [7:0] port_a_pullup_o,
    input wire logic [7:0] port_b_pin_i,
    input wire gpab_pkg::gpab_pins_s port_b_pin_o,
    input wire logic [7:0] keyboard_irq_enable_i,
    input wire logic [7:0] keyboard_pin_o,
    input wire logic [7:0] keyboard_irq_active_o,
    input wire logic [4:0] converter_channel_select_i,
    input wire logic converter_analog_o
);
    // ========
    // Helpers
    logic [7:0] s1;
    logic [7:0] s2;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i) {s2, s1} <= 16'h0000;
        else {s2, s1} <= {s1, port_b_pin_i};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_dir_a;
        reg_write_i && reg_addr_i == gpab_pkg::ADDR_PORT_A_DIRECTION;
    endsequence
    sequence s_dir_b;
        reg_write_i && reg_addr_i == gpab_pkg::ADDR_PORT_B_DIRECTION;
    endsequence
    sequence s_quiet_a;
        $stable(port_a_pin_i) [*5];
    endsequence
    sequence s_quiet_b;
        ($stable(port_b_pin_i) && $stable(converter_channel_select_i)) [*5];
    endsequence
    // ========
    // Properties
    // Pins 6, 3 and 2 may be taken by other units, so they are masked.
    property p_dir_a;
        s_dir_a |-> ##2
            ((port_a_pin_o.oe ^ $past(reg_wdata_i, 2)) & 8'hB3) == 8'h00;
    endproperty
    property p_dir_b;
        s_dir_b |-> ##2 port_b_pin_o.oe == $past(reg_wdata_i, 2);
    endproperty
    property p_rst;
        $rose(nrst_i) |-> port_a_pin_o.oe == 8'h00
            && port_b_pin_o.oe == 8'h00 && port_a_pullup_o == 8'h00;
    endproperty
    property p_pull;
        (port_a_pullup_o & port_a_pin_o.oe) == 8'h00;
    endproperty
    property p_rd_b;
        reg_read_i && reg_addr_i == gpab_pkg::ADDR_PORT_B_DATA
            && port_b_pin_o.oe == 8'h00 |=> reg_rdata_o == $past(s2);
    endproperty
    property p_idle;
        !reg_read_i |=> reg_rdata_o == 8'h00;
    endproperty
    property p_kbd;
        (keyboard_irq_active_o & ~$past(keyboard_irq_enable_i)) == 8'h00;
    endproperty
    property p_sync;
        s_quiet_a |-> keyboard_pin_o == port_a_pin_i;
    endproperty
    property p_adc;
        s_quiet_b |-> converter_analog_o == (converter_channel_select_i < 5'h08
            ? port_b_pin_i[converter_channel_select_i[2:0]] : 1'b0);
    endproperty
    a_dir_a: assert property (p_dir_a)
        else $error("port A drive does not follow direction");
    a_dir_b: assert property (p_dir_b)
        else $error("port B drive does not follow direction");
    a_rst: assert property (p_rst)
        else $error("pins not inputs after reset");
    a_pull: assert property (p_pull)
        else $error("pull-up on a driven pin");
    a_rd_b: assert property (p_rd_b)
        else $error("port B input read wrong");
    a_idle: assert property (p_idle)
        else $error("read data without read");
    a_kbd: assert property (p_kbd)
        else $error("keyboard input without enable");
    a_sync: assert property (p_sync)
        else $error("keyboard pin level wrong");
    a_adc: assert property (p_adc)
        else $error("converter channel wrong");
endmodule // gpab_ports_assertions
bind gpab_ports gpab_ports_assertions chk_u (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .port_a_pin_i(port_a_pin_i),
    .port_a_pin_o(port_a_pin_o), .port_a_pullup_o(port_a_pullup_o),
    .port_b_pin_i(port_b_pin_i), .port_b_pin_o(port_b_pin_o),
    .keyboard_irq_enable_i(keyboard_irq_enable_i),
    .keyboard_pin_o(keyboard_pin_o),
    .keyboard_irq_active_o(keyboard_irq_active_o),
    .converter_channel_select_i(converter_channel_select_i),
    .converter_analog_o(converter_analog_o));
`default_nettype wire

/* test/gpab_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gpab_board_model
(
    input wire logic sys_clk_i,
    input wire gpab_pkg::gpab_pins_s a_pins_i,
    input wire logic [7:0] a_pullup_i,
    input wire gpab_pkg::gpab_pins_s b_pins_i,
    input wire logic [7:0] a_drv_en_i,
    input wire logic [7:0] a_drv_i,
    input wire logic [7:0] b_drv_en_i,
    input wire logic [7:0] b_drv_i,
    output logic [7:0] a_level_o,
    output logic [7:0] b_level_o
);
    // Undriven lines without a pull-up wander every cycle so a stale value never reads back.
    logic flip = 1'b0;
    logic [7:0] a_ext;
    logic [7:0] b_ext;
    always @(posedge sys_clk_i) flip <= ~flip;
    assign a_ext = (a_drv_en_i & a_drv_i)
        | (~a_drv_en_i & (a_pullup_i | {8{flip}}));
    assign b_ext = (b_drv_en_i & b_drv_i)
        | (~b_drv_en_i & {8{flip}});
    assign a_level_o = (a_pins_i.oe & a_pins_i.out)
        | (~a_pins_i.oe & a_ext);
    assign b_level_o = (b_pins_i.oe & b_pins_i.out)
        | (~b_pins_i.oe & b_ext);
endmodule // gpab_board_model
`default_nettype wire

/* test/gpab_ports_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gpab_ports_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] dir;
        logic [7:0] lat;
        logic [7:0] pin;
        logic [7:0] exp;
    } gpab_row_s;
    logic clk, nrst, we, re, rc, sdo, sde, slo, sle, ana, sdi, sli;
    logic [7:0] addr, wdata, rdata, a_in, b_in, pull, kbe, kact;
    logic [7:0] aen, av, ben, bv;
    logic [4:0] sel;
    gpab_pkg::gpab_pins_s a_out, b_out;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    gpab_row_s rows [6] = '{
        '{8'h00, 8'h00, 8'hFF, 8'hA5, 8'hA5},
        '{8'h00, 8'hFF, 8'h3C, 8'hC3, 8'h3C},
        '{8'h00, 8'h0F, 8'h96, 8'h5A, 8'h56},
        '{8'h01, 8'h00, 8'hFF, 8'hA5, 8'hA5},
        '{8'h01, 8'hFF, 8'h3C, 8'hC3, 8'h3C},
        '{8'h01, 8'h0F, 8'h96, 8'h5A, 8'h56}};
    gpab_ports dut_u (.sys_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(we), .reg_read_i(re),
        .reg_rdata_o(rdata), .port_a_pin_i(a_in), .port_a_pin_o(a_out),
        .port_a_pullup_o(pull), .port_b_pin_i(b_in), .port_b_pin_o(b_out),
        .keyboard_irq_enable_i(kbe), .keyboard_pin_o(),
        .keyboard_irq_active_o(kact), .rc_clock_i(rc),
        .two_wire_sda_out_i(sdo), .two_wire_sda_oe_i(sde),
        .two_wire_scl_out_i(slo), .two_wire_scl_oe_i(sle),
        .two_wire_sda_o(sdi), .two_wire_scl_o(sli),
        .converter_channel_select_i(sel), .converter_analog_o(ana));
    gpab_board_model board_u (.sys_clk_i(clk), .a_pins_i(a_out),
        .a_pullup_i(pull), .b_pins_i(b_out), .a_drv_en_i(aen), .a_drv_i(av),
        .b_drv_en_i(ben), .b_drv_i(bv), .a_level_o(a_in), .b_level_o(b_in));
    // ========
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // Checks run just after an edge so registered outputs have settled.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ========
    // Clock, watchdog and sequence
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            err_total++;
            print_verdict();
        end
    end
    initial
    begin
        {nrst, we, re, rc, sdo, sde, slo, sle} = 8'h08;
        {addr, wdata, kbe, aen, av, ben, bv} = 56'h0;
        sel = 5'h00;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h0D, 8'h80);
        rd(8'h0E, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h20, 8'h00);
        foreach (rows[i])
        begin
            @(posedge clk);
            {aen, ben, av, bv} <= {16'hFFFF, rows[i].pin, rows[i].pin};
            wr(rows[i].a, rows[i].lat);
            wr(rows[i].a + 8'h04, rows[i].dir);
            repeat (4) @(posedge clk);
            rd(rows[i].a, rows[i].exp);
            chk(rows[i].a[0] ? b_out.oe : a_out.oe, rows[i].dir);
            chk(rows[i].a[0] ? b_out.out : a_out.out, rows[i].lat);
        end
        @(posedge clk);
        aen <= 8'h00;
        wr(8'h0D, 8'hFF);
        wr(8'h0E, 8'h01);
        wr(8'h00, 8'h09);
        wr(8'h04, 8'h0F);
        settle(4);
        chk(pull, 8'hF0);
        rd(8'h00, 8'hF9);
        wr(8'h0E, 8'h00);
        settle(3);
        chk(pull, 8'h70);
        @(posedge clk);
        rc <= 1'b1;
        wr(8'h0D, 8'h7F);
        settle(3);
        chk(a_out.oe, 8'h4F);
        chk(pull, 8'h30);
        chk({7'h00, a_out.out[6]}, 8'h01);
        wr(8'h10, 8'h01);
        settle(3);
        chk(a_out.oe, 8'h0F);
        @(posedge clk);
        {sde, sdo, kbe, aen, av} <= {2'b11, 8'hFF, 8'h08, 8'h00};
        wr(8'h0D, 8'hFF);
        wr(8'h10, 8'h06);
        wr(8'h04, 8'h00);
        settle(4);
        chk(a_out.oe, 8'h04);
        chk({7'h00, a_out.out[2]}, 8'h01);
        chk({6'h00, sli, sdi}, 8'h01);
        chk(kact, 8'hF3);
        chk(pull, 8'h7B);
        wr(8'h10, 8'h04);
        settle(4);
        chk(a_out.oe, 8'h00);
        chk(kact, 8'hFF);
        @(posedge clk);
        {ben, bv} <= 16'hFF08;
        wr(8'h05, 8'h00);
        sel <= 5'h03;
        settle(8);
        chk({7'h00, ana}, 8'h01);
        @(posedge clk);
        sel <= 5'h0B;
        settle(8);
        chk({7'h00, ana}, 8'h00);
        wr(8'h00, 8'h3C);
        wr(8'h01, 8'hC5);
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        #1 chk(a_out.oe, 8'h00);
        chk(b_out.oe, 8'h00);
        wr(8'h04, 8'hFF);
        wr(8'h05, 8'hFF);
        rd(8'h00, 8'h3C);
        rd(8'h01, 8'hC5);
        print_verdict();
    end
endmodule // gpab_ports_tb
`default_nettype wire
